// ### hdl/tcs_cfg.svh
`ifndef TCS_CFG_SVH
`define TCS_CFG_SVH

// ==========================================================
// Clock and timing
`define TCS_CLK_PERIOD_NS 8
`define TCS_POWERUP_NS 1500000
`define TCS_CONV_NS 15500000
`define TCS_TIMEOUT_MIN_NS 20000000
`define TCS_TIMEOUT_MAX_NS 40000000
`define TCS_CYCLE_STEP_NS 250000000

// ==========================================================
// Register byte offsets
`define TCS_ADDR_RESULT 8'h00
`define TCS_ADDR_CONFIG 8'h04
`define TCS_ADDR_HIGH 8'h08
`define TCS_ADDR_LOW 8'h0c
`define TCS_ADDR_STATUS 8'h10

// ==========================================================
// Configuration field positions
`define TCS_CFG_READY_BIT 13
`define TCS_CFG_MODE_LSB 10
`define TCS_CFG_CONV_LSB 7
`define TCS_CFG_AVG_LSB 5
`define TCS_CFG_PIN_BIT 2

// ==========================================================
// Codes and reset values
`define TCS_MODE_CONT 2'b00
`define TCS_MODE_HALT 2'b01
`define TCS_MODE_ONESHOT 2'b11
`define TCS_AVG_NONE 2'b00
`define TCS_AVG_SHIFT 3
`define TCS_AVG_LAST 3'h7
`define TCS_RESULT_RST 16'h8000
`define TCS_MODE_RST 2'b00
`define TCS_CONV_RST 3'h3
`define TCS_AVG_RST 2'b01
`define TCS_HIGH_RST 16'h7fff
`define TCS_LOW_RST 16'h8000

`endif

// ### hdl/tcs_pkg.sv
package tcs_pkg;

  // Gray order along load, active, standby
  typedef enum logic [2:0] {
    st_load = 3'b000,
    st_active = 3'b001,
    st_standby = 3'b011,
    st_halt = 3'b010
  } tcs_state_type;

endpackage

// ### hdl/tcs_sync.sv
`timescale 1ns/1ps
`default_nettype none

module tcs_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Data
  input wire logic [WIDTH-1:0] d_in,
  output logic [WIDTH-1:0] q_out
);

  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      meta <= '0;
      q_out <= '0;
    end else begin
      meta <= d_in;
      q_out <= meta;
    end
  end

endmodule

`default_nettype wire

// ### hdl/tcs_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcs_cfg.svh"

module tcs_sequencer #(
  parameter int ADDR_W = 8,
  parameter int POWERUP_CYC =
    (`TCS_POWERUP_NS + `TCS_CLK_PERIOD_NS - 1) / `TCS_CLK_PERIOD_NS,
  parameter int CONV_CYC =
    (`TCS_CONV_NS + `TCS_CLK_PERIOD_NS - 1) / `TCS_CLK_PERIOD_NS,
  parameter int TIMEOUT_CYC =
    (`TCS_TIMEOUT_MIN_NS + `TCS_CLK_PERIOD_NS - 1) / `TCS_CLK_PERIOD_NS,
  parameter int CYCLE_STEP_CYC = `TCS_CYCLE_STEP_NS / `TCS_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Serial bus watch
  input wire logic scl_in,
  input wire logic bus_sda_hold_in,
  output logic sda_release_out,
  // Converter front end
  output logic adc_active_out,
  input wire logic [15:0] adc_sample_in,
  // Pins
  input wire logic startup_halt_in,
  output logic alert_out
);

  localparam logic [31:0] PU_LAST = 32'(POWERUP_CYC - 1);
  localparam logic [31:0] CONV_LAST = 32'(CONV_CYC - 1);
  localparam logic [31:0] TO_LAST = 32'(TIMEOUT_CYC - 1);
  localparam logic [31:0] STEP_CYC = 32'(CYCLE_STEP_CYC);

  // ==========================================================
  // Pin synchronisers
  logic [1:0] pins_s;
  logic scl_s;
  logic strap_s;
  logic scl_d;
  logic scl_edge;

  tcs_sync #(.WIDTH(2)) u_sync (
    .clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .d_in({startup_halt_in, scl_in}),
    .q_out(pins_s)
  );

  assign scl_s = pins_s[0];
  assign strap_s = pins_s[1];

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      scl_d <= 1'b0;
    end else begin
      scl_d <= scl_s;
    end
  end

  assign scl_edge = scl_s ^ scl_d;

  // ==========================================================
  // Bus inactivity timeout
  logic [31:0] to_cnt;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      to_cnt <= 32'h0;
      sda_release_out <= 1'b0;
    end else if (!bus_sda_hold_in || scl_edge) begin
      to_cnt <= 32'h0;
      sda_release_out <= 1'b0;
    end else if (to_cnt == TO_LAST) begin
      sda_release_out <= 1'b1;
    end else begin
      to_cnt <= to_cnt + 32'h1;
    end
  end

  // ==========================================================
  // Registers and APB access
  tcs_pkg::tcs_state_type state;
  tcs_pkg::tcs_state_type next_state;
  logic load_busy;
  logic [31:0] pu_cnt;
  logic [1:0] conversion_mode_field;
  logic [2:0] cycle_time_field;
  logic [1:0] averaging_count_field;
  logic ready_on_pin_select;
  logic ready_flag;
  logic signed [15:0] result;
  logic signed [15:0] high_limit;
  logic signed [15:0] low_limit;
  logic apb_wr;
  logic apb_rd;
  logic addr_hit;
  logic [31:0] next_rdata;
  logic cfg_wr_ok;
  logic [1:0] wr_mode;
  logic rd_clear;
  logic conv_finish;
  logic pu_done;

  assign apb_wr = psel_in && penable_in && pwrite_in;
  assign apb_rd = psel_in && penable_in && !pwrite_in;
  assign pready_out = 1'b1;
  assign pslverr_out = psel_in && penable_in && !addr_hit;
  assign cfg_wr_ok = apb_wr && !load_busy &&
    paddr_in == ADDR_W'(`TCS_ADDR_CONFIG);
  assign wr_mode = pwdata_in[`TCS_CFG_MODE_LSB +: 2];
  assign rd_clear = apb_rd && (paddr_in == ADDR_W'(`TCS_ADDR_RESULT) ||
    paddr_in == ADDR_W'(`TCS_ADDR_CONFIG));

  always_comb begin
    next_rdata = 32'h0;
    addr_hit = 1'b1;
    if (paddr_in == ADDR_W'(`TCS_ADDR_RESULT)) begin
      next_rdata[15:0] = result;
    end else if (paddr_in == ADDR_W'(`TCS_ADDR_CONFIG)) begin
      next_rdata[`TCS_CFG_READY_BIT] = ready_flag;
      next_rdata[`TCS_CFG_MODE_LSB +: 2] = conversion_mode_field;
      next_rdata[`TCS_CFG_CONV_LSB +: 3] = cycle_time_field;
      next_rdata[`TCS_CFG_AVG_LSB +: 2] = averaging_count_field;
      next_rdata[`TCS_CFG_PIN_BIT] = ready_on_pin_select;
    end else if (paddr_in == ADDR_W'(`TCS_ADDR_HIGH)) begin
      next_rdata[15:0] = high_limit;
    end else if (paddr_in == ADDR_W'(`TCS_ADDR_LOW)) begin
      next_rdata[15:0] = low_limit;
    end else if (paddr_in == ADDR_W'(`TCS_ADDR_STATUS)) begin
      next_rdata[0] = load_busy;
      next_rdata[3:1] = state;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // Read data is captured in the setup cycle so the access cycle needs no wait
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0;
    end else if (psel_in && !penable_in && !pwrite_in) begin
      prdata_out <= next_rdata;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cycle_time_field <= `TCS_CONV_RST;
      averaging_count_field <= `TCS_AVG_RST;
      ready_on_pin_select <= 1'b0;
    end else if (cfg_wr_ok) begin
      cycle_time_field <= pwdata_in[`TCS_CFG_CONV_LSB +: 3];
      averaging_count_field <= pwdata_in[`TCS_CFG_AVG_LSB +: 2];
      ready_on_pin_select <= pwdata_in[`TCS_CFG_PIN_BIT];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      high_limit <= `TCS_HIGH_RST;
      low_limit <= `TCS_LOW_RST;
    end else if (apb_wr && !load_busy) begin
      if (paddr_in == ADDR_W'(`TCS_ADDR_HIGH)) begin
        high_limit <= pwdata_in[15:0];
      end else if (paddr_in == ADDR_W'(`TCS_ADDR_LOW)) begin
        low_limit <= pwdata_in[15:0];
      end
    end
  end

  // Strap is sampled only while loading, never under reset
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      conversion_mode_field <= `TCS_MODE_RST;
    end else if (load_busy) begin
      conversion_mode_field <= strap_s ? `TCS_MODE_HALT : `TCS_MODE_RST;
    end else if (cfg_wr_ok) begin
      conversion_mode_field <= wr_mode;
    end else if (conv_finish && conversion_mode_field == `TCS_MODE_ONESHOT) begin
      conversion_mode_field <= `TCS_MODE_HALT;
    end
  end

  // ==========================================================
  // Power-up load interval
  assign pu_done = load_busy && pu_cnt == PU_LAST;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      load_busy <= 1'b1;
      pu_cnt <= 32'h0;
    end else if (pu_done) begin
      load_busy <= 1'b0;
    end else if (load_busy) begin
      pu_cnt <= pu_cnt + 32'h1;
    end
  end

  // ==========================================================
  // Conversion sequencing
  logic [31:0] slot_cnt;
  logic [31:0] cyc_cnt;
  logic [31:0] cycle_len;
  logic [2:0] conv_idx;
  logic slot_end;
  logic avg_on;
  logic cycle_over;
  logic restart;
  logic signed [18:0] acc;
  logic signed [18:0] next_sum;
  logic signed [18:0] avg_value;

  assign avg_on = averaging_count_field != `TCS_AVG_NONE;
  assign slot_end = state == tcs_pkg::st_active && slot_cnt == CONV_LAST;
  assign conv_finish = slot_end &&
    conv_idx == (avg_on ? `TCS_AVG_LAST : 3'h0);
  assign cycle_len = STEP_CYC * {28'h0, {1'b0, cycle_time_field} + 4'h1};
  assign cycle_over = cyc_cnt >= cycle_len - 32'h1;
  assign next_sum = acc + {{3{adc_sample_in[15]}}, adc_sample_in};
  assign avg_value = avg_on ? (next_sum >>> `TCS_AVG_SHIFT) : next_sum;

  always_comb begin
    next_state = state;
    restart = 1'b0;
    case (state)
      tcs_pkg::st_load: begin
        if (pu_done && strap_s) begin
          next_state = tcs_pkg::st_halt;
        end else if (pu_done) begin
          next_state = tcs_pkg::st_active;
          restart = 1'b1;
        end
      end
      default: begin
        if (cfg_wr_ok && wr_mode == `TCS_MODE_HALT) begin
          next_state = tcs_pkg::st_halt;
        end else if (cfg_wr_ok && wr_mode == `TCS_MODE_ONESHOT) begin
          next_state = tcs_pkg::st_active;
          restart = 1'b1;
        end else if (cfg_wr_ok && state == tcs_pkg::st_halt) begin
          next_state = tcs_pkg::st_active;
          restart = 1'b1;
        end else if (conv_finish && conversion_mode_field == `TCS_MODE_ONESHOT) begin
          next_state = tcs_pkg::st_halt;
        end else if (conv_finish && cycle_over) begin
          restart = 1'b1;
        end else if (conv_finish) begin
          next_state = tcs_pkg::st_standby;
        end else if (state == tcs_pkg::st_standby && cycle_over) begin
          next_state = tcs_pkg::st_active;
          restart = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      state <= tcs_pkg::st_load;
    end else begin
      state <= next_state;
    end
  end

  // Averaging uses the same path in every mode
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      slot_cnt <= 32'h0;
      conv_idx <= 3'h0;
      acc <= 19'sh0;
    end else if (restart) begin
      slot_cnt <= 32'h0;
      conv_idx <= 3'h0;
      acc <= 19'sh0;
    end else if (slot_end) begin
      slot_cnt <= 32'h0;
      conv_idx <= conv_idx + 3'h1;
      acc <= next_sum;
    end else if (state == tcs_pkg::st_active) begin
      slot_cnt <= slot_cnt + 32'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      cyc_cnt <= 32'h0;
    end else if (restart) begin
      cyc_cnt <= 32'h0;
    end else if (state == tcs_pkg::st_active || state == tcs_pkg::st_standby) begin
      cyc_cnt <= cyc_cnt + 32'h1;
    end
  end

  assign adc_active_out = state == tcs_pkg::st_active;

  // ==========================================================
  // Result, ready flag and alert pin
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      result <= `TCS_RESULT_RST;
    end else if (conv_finish) begin
      result <= avg_value[15:0];
    end
  end

  // Set beats a clearing read in the same cycle so no update is missed
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ready_flag <= 1'b0;
    end else if (conv_finish) begin
      ready_flag <= 1'b1;
    end else if (rd_clear) begin
      ready_flag <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      alert_out <= 1'b0;
    end else begin
      alert_out <= ready_on_pin_select && ready_flag;
    end
  end

  // ==========================================================
  // Checks
  logic seen_done;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      seen_done <= 1'b0;
    end else if (conv_finish) begin
      seen_done <= 1'b1;
    end
  end

  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  chk_sda_release_time: assert property ($rose(sda_release_out) |-> $past(to_cnt) == TO_LAST)
    else $error("data line released at wrong time");
  chk_load_no_conv: assert property (load_busy |-> !adc_active_out)
    else $error("conversion during power-up");
  chk_load_length: assert property ($fell(load_busy) |-> $past(pu_cnt) == PU_LAST)
    else $error("power-up interval wrong length");
  chk_strap_halt: assert property (pu_done && strap_s |=> state == tcs_pkg::st_halt)
    else $error("startup halt strap ignored");
  chk_result_before: assert property (!seen_done |-> result == `TCS_RESULT_RST)
    else $error("result changed before first conversion");
  chk_avg_eight: assert property (conv_finish && avg_on |-> conv_idx == 3'h7)
    else $error("averaged result after wrong count");
  chk_result_update: assert property (conv_finish |=> ready_flag && result == $past(avg_value[15:0]))
    else $error("result or ready not updated at conversion end");
  chk_ready_clear: assert property (rd_clear && !conv_finish |=> !ready_flag)
    else $error("ready flag not cleared by read");
  chk_alert_follow: assert property (ready_on_pin_select |=> alert_out == $past(ready_flag))
    else $error("alert pin does not follow ready");
  chk_standby_hold: assert property (state == tcs_pkg::st_standby && !cfg_wr_ok && !cycle_over |=> state == tcs_pkg::st_standby)
    else $error("standby left early");
  chk_halt_abort: assert property (cfg_wr_ok && wr_mode == `TCS_MODE_HALT |=> state == tcs_pkg::st_halt && !adc_active_out)
    else $error("halt write did not abort");
  chk_oneshot_end: assert property (conv_finish && conversion_mode_field == `TCS_MODE_ONESHOT && !cfg_wr_ok |=> state == tcs_pkg::st_halt)
    else $error("one-shot did not return to halt");
  chk_write_ignored: assert property (load_busy && apb_wr |=> $stable(cycle_time_field) && $stable(high_limit) && $stable(low_limit))
    else $error("write accepted during power-up");

endmodule

`default_nettype wire

// ### testbench/tcs_serial_host.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Serial host model: makes the link clock and holds the data line
module tcs_serial_host (
  // Clock
  input wire logic sys_clk_in,
  // Commands from the bench
  input wire logic frame_in,
  input wire logic hold_in,
  // Serial side
  output logic scl_out,
  output logic sda_hold_out
);
  initial begin
    scl_out = 1'b1;
    forever begin
      wait (frame_in);
      // Clock runs only inside frames; pull-up leaves it high between them
      while (frame_in) begin
        #62.5 scl_out = ~scl_out;
      end
      scl_out = 1'b1;
    end
  end

  // Hold is reported in the system domain, as the engine does
  always_ff @(posedge sys_clk_in) begin
    sda_hold_out <= hold_in;
  end
endmodule

`default_nettype wire

// ### testbench/tcs_sequencer_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcs_cfg.svh"

`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin fail_count++; \
  $display("[ERR] %0t got %h want %h", $time, got, exp); end end

module tcs_sequencer_bench;
  // ==========================================================
  // Shortened counts keep the run short
  localparam int PU = 20;
  localparam int CONV = 10;
  localparam int TO = 50;
  localparam int STEP = 100;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic scl;
  logic sda_hold;
  logic sda_rel;
  logic adc_act;
  logic alert;
  logic [15:0] adc_sample = 16'h0000;
  logic strap = 1'b0;
  logic frame = 1'b0;
  logic hold = 1'b0;
  logic act_d = 1'b0;
  logic [31:0] lfsr = 32'h5645;
  logic [31:0] rd;
  logic [31:0] keep;
  logic err;
  int fail_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int slot_cnt = 0;
  int rise_cyc = 0;
  int period = 0;
  int act_len = 0;
  int n_rise = 0;
  int rel = 0;
  int samples[$];

  initial begin
    forever #4 clk = ~clk;
  end

  tcs_sequencer #(.ADDR_W(8), .POWERUP_CYC(PU), .CONV_CYC(CONV), .TIMEOUT_CYC(TO),
    .CYCLE_STEP_CYC(STEP)) tcs_sequencer_inst (
    .sys_clk_in(clk), .rst_n_in(rst_n), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .scl_in(scl),
    .bus_sda_hold_in(sda_hold), .sda_release_out(sda_rel), .adc_active_out(adc_act),
    .adc_sample_in(adc_sample), .startup_halt_in(strap), .alert_out(alert));

  tcs_serial_host tcs_serial_host_inst (.sys_clk_in(clk), .frame_in(frame),
    .hold_in(hold), .scl_out(scl), .sda_hold_out(sda_hold));

  // ==========================================================
  // Reference model
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  function automatic logic [15:0] exp_avg(input int n);
    int sum;
    sum = 0;
    for (int i = samples.size() - n; i < samples.size(); i++) begin
      if (i >= 0) sum += samples[i];
    end
    return (n == 8) ? 16'(sum >>> 3) : 16'(sum);
  endfunction

  function automatic logic [31:0] cfg(input logic [1:0] m, input logic [2:0] c,
      input logic [1:0] a);
    return (32'(m) << `TCS_CFG_MODE_LSB) | (32'(c) << `TCS_CFG_CONV_LSB) |
      (32'(a) << `TCS_CFG_AVG_LSB) | (32'h1 << `TCS_CFG_PIN_BIT);
  endfunction

  // New sample mid-slot, so it is steady at the slot's last cycle
  always @(posedge clk) begin
    cyc <= cyc + 1;
    act_d <= adc_act;
    if (adc_act && !act_d) begin
      period <= cyc - rise_cyc;
      rise_cyc <= cyc;
      n_rise <= n_rise + 1;
      samples.delete();
    end
    if (!adc_act && act_d) act_len <= cyc - rise_cyc;
    slot_cnt <= adc_act ? slot_cnt + 1 : 0;
    if (adc_act && (slot_cnt % CONV) == 4) begin
      lfsr = lfsr_next(lfsr);
      adc_sample <= lfsr[15:0];
      samples.push_back(int'($signed(lfsr[15:0])));
    end
  end

  // ==========================================================
  // Bus and wait tasks
  task automatic tally_and_finish();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic abort_run();
    fail_count++;
    $display("[ERR] %0t wait expired", $time);
    tally_and_finish();
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (int i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) begin
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        return;
      end
    end
    abort_run();
  endtask

  // Selector: 0 alert, 1 converter active, 2 data line release
  task automatic wait_sig(input int sel, input logic lvl, input int lim);
    logic v;
    for (int i = 0; i < lim; i++) begin
      @(posedge clk);
      v = (sel == 0) ? alert : (sel == 1) ? adc_act : sda_rel;
      if (v === lvl) return;
    end
    abort_run();
  endtask

  task automatic conv_round(input int n, input logic chk);
    wait_sig(0, 1'b1, 900);
    apb(1'b0, `TCS_ADDR_RESULT, 32'h0);
    if (chk) `CHK(rd[15:0], exp_avg(n))
    repeat (2) @(posedge clk);
    `CHK(alert, 1'b0)
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rel = cyc;
    apb(1'b0, `TCS_ADDR_RESULT, 32'h0);
    `CHK(rd[15:0], 16'h8000)
    apb(1'b0, `TCS_ADDR_CONFIG, 32'h0);
    `CHK(rd[11:5], 7'b0001101)
    apb(1'b1, `TCS_ADDR_HIGH, 32'h1234);
    `CHK(adc_act, 1'b0)
    wait_sig(1, 1'b1, 60);
    `CHK(cyc - rel >= PU, 1'b1)
    apb(1'b0, `TCS_ADDR_HIGH, 32'h0);
    `CHK(rd[15:0], 16'h7fff)
    apb(1'b1, `TCS_ADDR_LOW, 32'hf380);
    apb(1'b0, `TCS_ADDR_LOW, 32'h0);
    `CHK(rd[15:0], 16'hf380)
    apb(1'b1, `TCS_ADDR_CONFIG, cfg(2'b00, 3'h1, 2'b01));
    wait_sig(0, 1'b1, 300);
    apb(1'b0, `TCS_ADDR_CONFIG, 32'h0);
    `CHK(rd[`TCS_CFG_READY_BIT], 1'b1)
    apb(1'b0, `TCS_ADDR_CONFIG, 32'h0);
    `CHK(rd[`TCS_CFG_READY_BIT], 1'b0)
    apb(1'b0, `TCS_ADDR_RESULT, 32'h0);
    `CHK(rd[15:0], exp_avg(8))
    for (int i = 0; i < 2; i++) conv_round(8, 1'b1);
    `CHK(period, 2 * STEP)
    `CHK(act_len, 8 * CONV)
    apb(1'b1, `TCS_ADDR_CONFIG, cfg(2'b10, 3'h1, 2'b00));
    conv_round(1, 1'b0);
    for (int i = 0; i < 2; i++) conv_round(1, 1'b1);
    `CHK(act_len, CONV)
    `CHK(period, 2 * STEP)
    // Abort lands in mid-conversion
    wait_sig(1, 1'b1, 300);
    repeat (3) @(posedge clk);
    apb(1'b1, `TCS_ADDR_CONFIG, cfg(2'b01, 3'h1, 2'b01));
    repeat (2) @(posedge clk);
    `CHK(adc_act, 1'b0)
    apb(1'b0, `TCS_ADDR_STATUS, 32'h0);
    `CHK(rd[3:1], 3'b010)
    repeat (300) @(posedge clk);
    `CHK({adc_act, alert}, 2'b00)
    apb(1'b1, `TCS_ADDR_CONFIG, cfg(2'b11, 3'h7, 2'b01));
    conv_round(8, 1'b1);
    `CHK(act_len, 8 * CONV)
    apb(1'b0, `TCS_ADDR_CONFIG, 32'h0);
    `CHK(rd[11:10], 2'b01)
    rel = n_rise;
    repeat (900) @(posedge clk);
    `CHK(n_rise, rel)
    // Bus errors and read-only places
    apb(1'b0, 8'h14, 32'h0);
    `CHK({err, rd}, {1'b1, 32'h0})
    apb(1'b0, `TCS_ADDR_RESULT, 32'h0);
    keep = rd;
    apb(1'b1, `TCS_ADDR_RESULT, 32'h5555);
    apb(1'b0, `TCS_ADDR_RESULT, 32'h0);
    `CHK(rd, keep)
    // Bus inactivity timeout
    hold <= 1'b1;
    rel = cyc;
    wait_sig(2, 1'b1, TO + 20);
    `CHK(cyc - rel >= TO, 1'b1)
    frame <= 1'b1;
    wait_sig(2, 1'b0, 30);
    repeat (200) @(posedge clk);
    `CHK(sda_rel, 1'b0)
    frame <= 1'b0;
    wait_sig(2, 1'b1, TO + 40);
    hold <= 1'b0;
    wait_sig(2, 1'b0, 10);
    repeat (100) @(posedge clk);
    `CHK(sda_rel, 1'b0)
    // Startup strap into halt
    rst_n <= 1'b0;
    strap <= 1'b1;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    repeat (PU + 20) @(posedge clk);
    `CHK(adc_act, 1'b0)
    apb(1'b0, `TCS_ADDR_STATUS, 32'h0);
    `CHK(rd[3:1], 3'b010)
    tally_and_finish();
  end
endmodule

`default_nettype wire
